// [core/quick_event_pkg.sv]
// constants, register map and carrier types for the quick event bank
package quick_event_pkg;
  localparam int unsigned CHANNELS = 8;
  localparam int unsigned ADDR_W   = 6;

  // byte offsets of the 32-bit register words
  localparam logic [5:0] OFS_PENDING      = 6'h00;
  localparam logic [5:0] OFS_MISSED       = 6'h04;
  localparam logic [5:0] OFS_MISSED_CLEAR = 6'h08;
  localparam logic [5:0] OFS_ENABLE       = 6'h0C;
  localparam logic [5:0] OFS_ENABLE_CLEAR = 6'h10;
  localparam logic [5:0] OFS_ENABLE_SET   = 6'h14;
  localparam logic [5:0] OFS_QUEUED       = 6'h18;
  localparam logic [5:0] OFS_QUEUED_CLEAR = 6'h1C;

  localparam logic [7:0]  RESET_BITS = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [5:0] address;
    logic [31:0] writedata;
  } avalon_req_t;

  // per-channel event signals from the controller core
  typedef struct packed {
    logic [7:0] trigger;
    logic [7:0] queued;
    logic [7:0] submitted;
    logic [7:0] null_done;
  } event_in_t;

  typedef struct packed {
    logic [7:0]  pending;
    logic [7:0]  missed;
    logic [7:0]  enable;
    logic [7:0]  queued;
    logic [7:0]  prioritize;
    logic        waitrequest;
    logic        readdatavalid;
    logic [31:0] readdata;
  } bank_state_t;
endpackage

// [core/quick_event_bank.sv]
// enable, pending, missed and queued status bank for eight quick channels
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
module quick_event_bank (
  input  wire logic                        CLOCK,
  input  wire logic                        NRST,
  input  wire logic                        READ,
  input  wire logic                        WRITE,
  input  wire logic [5:0]                  ADDRESS,
  input  wire logic [31:0]                 WRITEDATA,
  input  wire logic [7:0]                  TRIGGER,
  input  wire logic [7:0]                  QUEUED_IN,
  input  wire logic [7:0]                  SUBMITTED,
  input  wire logic [7:0]                  NULL_DONE,
  output logic                             WAITREQUEST,
  output logic [31:0]                      READDATA,
  output logic [7:0]                       PENDING,
  output logic [7:0]                       ENABLE,
  output logic [7:0]                       QUEUED,
  output logic [7:0]                       MISSED,
  output logic [7:0]                       PRIORITIZE
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  quick_event_pkg::avalon_req_t req;
  quick_event_pkg::event_in_t   ev;
  quick_event_pkg::bank_state_t st;
  quick_event_pkg::bank_state_t next_st;

  assign req = '{READ, WRITE, ADDRESS, WRITEDATA};
  assign ev  = '{TRIGGER, QUEUED_IN, SUBMITTED, NULL_DONE};

  function automatic logic [7:0] wr_bits(
    input quick_event_pkg::avalon_req_t r,
    input logic [5:0] ofs,
    input logic busy
  );
    logic hit;
    hit = r.write && busy && (r.address == ofs);
    wr_bits = hit ? r.writedata[7:0] : quick_event_pkg::RESET_BITS;
  endfunction

  function automatic logic [31:0] zext(input logic [7:0] v);
    zext = {24'h000000, v};
  endfunction

  logic [7:0] en_clr;
  logic [7:0] en_set;
  logic [7:0] q_clr;
  logic [7:0] m_clr;
  logic       access;
  logic       commit;

  // first cycle of a request: waitrequest high, read data is prepared;
  // second cycle: waitrequest low, the master completes on this edge,
  // so writes land here and nowhere else
  assign access = (req.read || req.write) && st.waitrequest;
  assign commit = (req.read || req.write) && !st.waitrequest;
  assign en_clr = wr_bits(req, quick_event_pkg::OFS_ENABLE_CLEAR,
                          commit);
  assign en_set = wr_bits(req, quick_event_pkg::OFS_ENABLE_SET,
                          commit);
  assign q_clr  = wr_bits(req, quick_event_pkg::OFS_QUEUED_CLEAR,
                          commit);
  assign m_clr  = wr_bits(req, quick_event_pkg::OFS_MISSED_CLEAR,
                          commit);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] latch;
    logic [7:0] hw_clr;
    latch  = 8'h00;
    hw_clr = 8'h00;
    next_st = st;
    // enable changes only via set/clear; set wins if both hit
    next_st.enable = (st.enable & ~en_clr) | en_set;
    latch  = ev.trigger & st.enable;
    hw_clr = ev.submitted;
    // hardware set beats hardware and software clears
    next_st.pending = (st.pending & ~hw_clr & ~q_clr)
                      | latch;
    next_st.missed = (st.missed & ~m_clr)
                     | (latch & st.pending);
    // queued: set by core, cleared by null completion or software
    next_st.queued = (st.queued & ~ev.null_done & ~q_clr)
                     | ev.queued;
    // only pending, not queued channels go to prioritization
    next_st.prioritize = next_st.pending & ~next_st.queued;
    next_st.waitrequest = 1'b1;
    next_st.readdatavalid = 1'b0;
    if (access) begin
      next_st.waitrequest = 1'b0;
      next_st.readdatavalid = req.read;
      next_st.readdata = quick_event_pkg::RESET_WORD;
      if (req.read) begin
        case (req.address)
          quick_event_pkg::OFS_PENDING: begin
            next_st.readdata = zext(st.pending);
          end
          quick_event_pkg::OFS_MISSED: begin
            next_st.readdata = zext(st.missed);
          end
          quick_event_pkg::OFS_ENABLE: begin
            next_st.readdata = zext(st.enable);
          end
          quick_event_pkg::OFS_QUEUED: begin
            next_st.readdata = zext(st.queued);
          end
          default: begin
            next_st.readdata = quick_event_pkg::RESET_WORD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      st.pending       <= quick_event_pkg::RESET_BITS;
      st.missed        <= quick_event_pkg::RESET_BITS;
      st.enable        <= quick_event_pkg::RESET_BITS;
      st.queued        <= quick_event_pkg::RESET_BITS;
      st.prioritize    <= quick_event_pkg::RESET_BITS;
      st.waitrequest   <= 1'b1;
      st.readdatavalid <= 1'b0;
      st.readdata      <= quick_event_pkg::RESET_WORD;
    end else begin
      st <= next_st;
    end
  end

  assign WAITREQUEST = st.waitrequest;
  assign READDATA    = st.readdata;
  assign PENDING     = st.pending;
  assign ENABLE      = st.enable;
  assign QUEUED      = st.queued;
  assign MISSED      = st.missed;
  assign PRIORITIZE  = st.prioritize;

  // ----------------------------------------------------------------
  // checks: bus handshake
  // ----------------------------------------------------------------
  a_accept_answer: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    access |=> !st.waitrequest)
    else $error("accepted request got no answer");

  a_commit_release: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    commit |=> st.waitrequest)
    else $error("waitrequest stayed low after completion");

  a_idle_waits: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (!READ && !WRITE) |=> st.waitrequest)
    else $error("waitrequest low without request");

  a_wait_low_once: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    !st.waitrequest |=> st.waitrequest)
    else $error("waitrequest low for more than one cycle");

  a_read_valid: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (access && READ) |=> st.readdatavalid)
    else $error("read data not marked valid");

  a_write_no_valid: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (access && WRITE) |=> !st.readdatavalid)
    else $error("write marked as read data");

  // ----------------------------------------------------------------
  // checks: enable
  // ----------------------------------------------------------------
  a_enable_set_bit: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (commit && WRITE && ADDRESS == quick_event_pkg::OFS_ENABLE_SET
     && WRITEDATA[3]) |=> st.enable[3])
    else $error("enable set lost");

  a_enable_set_keep: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (commit && WRITE && ADDRESS == quick_event_pkg::OFS_ENABLE_SET
     && !WRITEDATA[7]) |=> st.enable[7] == $past(st.enable[7]))
    else $error("enable set changed a bit written zero");

  a_enable_clear_bit: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (commit && WRITE && ADDRESS == quick_event_pkg::OFS_ENABLE_CLEAR
     && WRITEDATA[4]) |=> !st.enable[4])
    else $error("enable clear lost");

  a_enable_clear_keep: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (commit && WRITE && ADDRESS == quick_event_pkg::OFS_ENABLE_CLEAR
     && !WRITEDATA[2]) |=> st.enable[2] == $past(st.enable[2]))
    else $error("enable clear changed a bit written zero");

  a_enable_direct_wr: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (commit && WRITE && ADDRESS == quick_event_pkg::OFS_ENABLE)
    |=> st.enable == $past(st.enable))
    else $error("direct enable write changed it");

  a_enable_no_bus: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    !(commit && WRITE) |=> st.enable == $past(st.enable))
    else $error("enable changed without a bus write");

  a_enable_read: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (access && READ && ADDRESS == quick_event_pkg::OFS_ENABLE)
    |=> READDATA[7:0] == $past(st.enable))
    else $error("enable read wrong");

  // ----------------------------------------------------------------
  // checks: pending
  // ----------------------------------------------------------------
  a_disabled_no_latch: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    $rose(st.pending[3]) |-> $past(st.enable[3]) && $past(TRIGGER[3]))
    else $error("pending rose without enabled trigger");

  a_disabled_ignore: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (TRIGGER[6] && !st.enable[6] && !st.pending[6]) |=> !st.pending[6])
    else $error("disabled channel latched an event");

  a_trigger_latch: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (TRIGGER[5] && st.enable[5]) |=> st.pending[5])
    else $error("enabled trigger not latched");

  a_set_wins: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (TRIGGER[1] && st.enable[1] && SUBMITTED[1]) |=> st.pending[1])
    else $error("pending clear beat set");

  a_submit_clears: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (SUBMITTED[3] && !TRIGGER[3]) |=> !st.pending[3])
    else $error("submitted request left pending set");

  a_set_over_clear: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (commit && WRITE && ADDRESS == quick_event_pkg::OFS_QUEUED_CLEAR
     && WRITEDATA[2] && TRIGGER[2] && st.enable[2]) |=> st.pending[2])
    else $error("software clear beat pending set");

  a_pending_hold: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (!TRIGGER[1] && !SUBMITTED[1] && !commit)
    |=> st.pending[1] == $past(st.pending[1]))
    else $error("pending changed without cause");

  // ----------------------------------------------------------------
  // checks: missed
  // ----------------------------------------------------------------
  a_missed_event: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (TRIGGER[1] && st.enable[1] && st.pending[1]) |=> st.missed[1])
    else $error("missed event not recorded");

  a_missed_quiet: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (!st.missed[5] && !(TRIGGER[5] && st.pending[5])) |=> !st.missed[5])
    else $error("missed set without a lost event");

  a_missed_clear: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (commit && WRITE && ADDRESS == quick_event_pkg::OFS_MISSED_CLEAR
     && WRITEDATA[2] && !TRIGGER[2]) |=> !st.missed[2])
    else $error("missed clear lost");

  a_missed_read: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (access && READ && ADDRESS == quick_event_pkg::OFS_MISSED)
    |=> READDATA[7:0] == $past(st.missed))
    else $error("missed read wrong");

  // ----------------------------------------------------------------
  // checks: queued
  // ----------------------------------------------------------------
  a_queued_follow: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    QUEUED_IN[5] |=> st.queued[5])
    else $error("queued bit not set");

  a_queued_hold: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (!QUEUED_IN[5] && !NULL_DONE[5] && !commit)
    |=> st.queued[5] == $past(st.queued[5]))
    else $error("queued changed without cause");

  a_null_clears: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (NULL_DONE[2] && !QUEUED_IN[2]) |=> !st.queued[2])
    else $error("hardware clear of queued lost");

  a_queued_clear: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (commit && WRITE && ADDRESS == quick_event_pkg::OFS_QUEUED_CLEAR
     && WRITEDATA[5] && !QUEUED_IN[5] && !TRIGGER[5])
    |=> !st.queued[5] && !st.pending[5])
    else $error("queued clear incomplete");

  a_queued_blocks: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    st.queued[2] |-> !PRIORITIZE[2])
    else $error("queued channel prioritized");

  a_prio_pending: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    PRIORITIZE[1] |-> st.pending[1])
    else $error("channel prioritized without pending event");

  a_queued_read: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (access && READ && ADDRESS == quick_event_pkg::OFS_QUEUED)
    |=> READDATA[7:0] == $past(st.queued))
    else $error("queued read wrong");

  // ----------------------------------------------------------------
  // checks: zero reads
  // ----------------------------------------------------------------
  a_wo_reads_zero: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (access && READ && ADDRESS == quick_event_pkg::OFS_ENABLE_SET)
    |=> READDATA == 32'h0000_0000 && !WAITREQUEST)
    else $error("write-only read not zero");

  a_wo_clear_zero: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (access && READ && ADDRESS == quick_event_pkg::OFS_QUEUED_CLEAR)
    |=> READDATA == 32'h0000_0000)
    else $error("queued clear read not zero");

  a_reserved_zero: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    READDATA[31:8] == 24'h000000)
    else $error("reserved read bits not zero");
endmodule

// [sim/tb_top.sv]
// self-checking bench for the quick event bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        CLOCK;
  logic        NRST;
  logic        READ;
  logic        WRITE;
  logic [5:0]  ADDRESS;
  logic [31:0] WRITEDATA;
  logic [7:0]  TRIGGER;
  logic [7:0]  QUEUED_IN;
  logic [7:0]  SUBMITTED;
  logic [7:0]  NULL_DONE;
  logic        WAITREQUEST;
  logic [31:0] READDATA;
  logic [7:0]  PENDING;
  logic [7:0]  ENABLE;
  logic [7:0]  QUEUED;
  logic [7:0]  MISSED;
  logic [7:0]  PRIORITIZE;
  int          failures;
  int          n_compared;

  quick_event_bank dut (
    .CLOCK(CLOCK), .NRST(NRST), .READ(READ), .WRITE(WRITE),
    .ADDRESS(ADDRESS), .WRITEDATA(WRITEDATA), .TRIGGER(TRIGGER),
    .QUEUED_IN(QUEUED_IN), .SUBMITTED(SUBMITTED), .NULL_DONE(NULL_DONE),
    .WAITREQUEST(WAITREQUEST), .READDATA(READDATA), .PENDING(PENDING),
    .ENABLE(ENABLE), .QUEUED(QUEUED), .MISSED(MISSED),
    .PRIORITIZE(PRIORITIZE)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task conclude();
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle, held until waitrequest is seen low
  task access(input logic wr, input logic [5:0] a, input logic [31:0] d,
              output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLOCK);
    READ <= !wr;
    WRITE <= wr;
    ADDRESS <= a;
    WRITEDATA <= d;
    // waitrequest and read data are taken as they stood at the edge
    do begin
      @(posedge CLOCK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 20);
    if (WAITREQUEST !== 1'b0) begin
      failures++;
      $display("MISMATCH at %0t: bus access timed out", $time);
      conclude();
    end
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask

  task rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask

  // one-cycle pulses on the event inputs, then settle
  task ev(input logic [7:0] t, input logic [7:0] qi,
          input logic [7:0] s, input logic [7:0] nd);
    @(posedge CLOCK);
    TRIGGER <= t;
    QUEUED_IN <= qi;
    SUBMITTED <= s;
    NULL_DONE <= nd;
    @(posedge CLOCK);
    TRIGGER <= 8'h00;
    QUEUED_IN <= 8'h00;
    SUBMITTED <= 8'h00;
    NULL_DONE <= 8'h00;
    @(negedge CLOCK);
  endtask

  // ----------------------------------------
  // clock, reset and sequence
  // ----------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  initial begin
    failures = 0;
    n_compared = 0;
    NRST = 1'b0;
    READ = 1'b0;
    WRITE = 1'b0;
    ADDRESS = 6'h00;
    WRITEDATA = 32'h0000_0000;
    TRIGGER = 8'h00;
    QUEUED_IN = 8'h00;
    SUBMITTED = 8'h00;
    NULL_DONE = 8'h00;
    repeat (16) @(posedge CLOCK);
    NRST <= 1'b1;
    rd(quick_event_pkg::OFS_ENABLE, 32'h0000_0000);
    rd(quick_event_pkg::OFS_ENABLE_CLEAR, 32'h0000_0000);
    rd(quick_event_pkg::OFS_ENABLE_SET, 32'h0000_0000);
    rd(quick_event_pkg::OFS_QUEUED_CLEAR, 32'h0000_0000);
    rd(6'h20, 32'h0000_0000);
    wr(quick_event_pkg::OFS_ENABLE, 32'h0000_00FF);
    rd(quick_event_pkg::OFS_ENABLE, 32'h0000_0000);
    wr(quick_event_pkg::OFS_ENABLE_SET, 32'hFFFF_FF7F);
    rd(quick_event_pkg::OFS_ENABLE, 32'h0000_007F);
    wr(quick_event_pkg::OFS_ENABLE_CLEAR, 32'h0000_00D1);
    rd(quick_event_pkg::OFS_ENABLE, 32'h0000_002E);
    ev(8'hFF, 8'h00, 8'h00, 8'h00);
    check({24'h00_0000, PENDING}, 32'h0000_002E);
    ev(8'h06, 8'h00, 8'h00, 8'h00);
    rd(quick_event_pkg::OFS_MISSED, 32'h0000_0006);
    ev(8'h02, 8'h00, 8'h0A, 8'h00);
    check({24'h00_0000, PENDING}, 32'h0000_0026);
    ev(8'h00, 8'h24, 8'h00, 8'h00);
    check({24'h00_0000, QUEUED}, 32'h0000_0024);
    check({24'h00_0000, PRIORITIZE}, 32'h0000_0002);
    ev(8'h00, 8'h00, 8'h00, 8'h04);
    rd(quick_event_pkg::OFS_QUEUED, 32'h0000_0020);
    wr(quick_event_pkg::OFS_QUEUED_CLEAR, 32'h0000_0020);
    rd(quick_event_pkg::OFS_QUEUED, 32'h0000_0000);
    rd(quick_event_pkg::OFS_PENDING, 32'h0000_0006);
    @(negedge CLOCK);
    check({24'h00_0000, ENABLE}, 32'h0000_002E);
    wr(quick_event_pkg::OFS_MISSED_CLEAR, 32'h0000_0004);
    rd(quick_event_pkg::OFS_MISSED, 32'h0000_0002);
    @(negedge CLOCK);
    check({24'h00_0000, MISSED}, 32'h0000_0002);
    // reset in mid-run returns every status bit to zero
    @(posedge CLOCK);
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    @(negedge CLOCK);
    check({ENABLE, PENDING, MISSED, QUEUED}, 32'h0000_0000);
    rd(quick_event_pkg::OFS_ENABLE, 32'h0000_0000);
    conclude();
  end
endmodule
